/* File: bench/pin_side_model.sv */
// pin and peripheral side model for the shared-pin gpio mux
`timescale 1ns/100ps
module pin_side_model
    import gpio_mux_pkg::*;
(
    // pins from the block
    input wire logic [port_count*byte_w-1:0] pin_out,
    input wire logic [port_count*byte_w-1:0] pin_oe,
    // outside drivers on pins the block leaves free
    input wire logic [port_count*byte_w-1:0] ext_level,
    // back to the block
    output logic [port_count*byte_w-1:0] pin_in,
    output logic [port_count*byte_w-1:0] prim_out,
    output logic [port_count*byte_w-1:0] prim_oe
);
    // a driven pin shows the block's level, a free one the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    // fixed peripheral pattern so the one-cycle pin lag compares cleanly
    assign prim_out = 48'hC3A5_5A3C_96E1;
    assign prim_oe = 48'hFFF0_FF0F_F0FF;
endmodule : pin_side_model

/* File: bench/tb_shared_pin_gpio_mux.sv */
// self-checking bench for the shared-pin gpio mux
`timescale 1ns/100ps
module tb_shared_pin_gpio_mux;
    import gpio_mux_pkg::*;
    localparam int pw = port_count*byte_w;
    logic clock, rst_b, wr_en, rd_en, rd_valid;
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wr_data, rd_data, mux_a, mux_b, mux_c;
    logic [pw-1:0] prim_out, prim_oe, prim_in, pin_in, pin_out, pin_oe, ext_level, mux_s;
    logic [data_w-1:0] port_s [port_count];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    shared_pin_gpio_mux dut_u (.clock(clock), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .mux_a(mux_a), .mux_b(mux_b), .mux_c(mux_c), .prim_out(prim_out),
        .prim_oe(prim_oe), .prim_in(prim_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    pin_side_model side_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in), .prim_out(prim_out), .prim_oe(prim_oe));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [pw-1:0] seen, input logic [pw-1:0] exp, input string s);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, s, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [addr_w-1:0] a, input logic [data_w-1:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [addr_w-1:0] a, input logic [data_w-1:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(pw'(rd_valid), pw'(1'b1), "read valid");
        check(pw'(rd_data), pw'(exp), "read data");
    endtask : rdchk
    // write and keep the bench's own copy of what the pins should do
    task automatic put(input logic [addr_w-1:0] a, input logic [data_w-1:0] d);
        wr(a, d);
        case (a)
            pin_mux_select_a_addr: mux_s[15:0] = d;
            pin_mux_select_b_addr: mux_s[31:16] = d;
            pin_mux_select_c_addr: mux_s[45:32] = d[13:0];
            port_a_data_direction_addr: port_s[port_a] = d;
            port_b_data_direction_addr: port_s[port_b] = d;
            port_c_data_direction_addr: port_s[port_c] = d;
            port_d_data_direction_addr: port_s[port_d] = d;
            port_e_data_direction_addr: port_s[port_e] = d;
            port_f_data_direction_addr: port_s[port_f] = d;
            default: ;
        endcase
    endtask : put
    // pins lag the register by an edge; waiting longer is harmless as they stand
    task automatic check_pins();
        logic [pw-1:0] dirv, datv, oe_x;
        repeat (3) @(posedge clock);
        #1;
        for (int p = 0; p < port_count; p++) begin
            dirv[p*byte_w+:byte_w] = port_s[p][15:8];
            datv[p*byte_w+:byte_w] = port_s[p][7:0];
        end
        oe_x = (mux_s & prim_oe) | (~mux_s & dirv);
        check(pin_oe, oe_x, "pin enable");
        check(pin_out & oe_x, ((mux_s & prim_out) | (~mux_s & datv)) & oe_x, "pin");
        check(prim_in, pin_in, "primary in");
        check(pw'({mux_c, mux_b, mux_a}), mux_s, "mux copies");
    endtask : check_pins

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk(pin_mux_select_a_addr, 16'h0000);
        rdchk(pin_mux_select_b_addr, 16'hFE03);
        rdchk(pin_mux_select_c_addr, 16'h0001);
        check_pins();
    endtask : t_reset
    task automatic t_direction();
        put(port_a_data_direction_addr, 16'hFF55);
        put(port_b_data_direction_addr, 16'h0F3C);
        check_pins();
        rdchk(port_a_data_direction_addr, 16'hFF55);
        rdchk(port_b_data_direction_addr, 16'h0FAC);
        @(posedge clock);
        ext_level[15:8] <= 8'h5A;
        check_pins();
        rdchk(port_b_data_direction_addr, 16'h0F5C);
    endtask : t_direction
    task automatic t_primary();
        put(pin_mux_select_a_addr, 16'h00FF);
        check_pins();
        put(port_a_data_direction_addr, 16'h00AA);
        check_pins();
        put(pin_mux_select_a_addr, 16'h0000);
        check_pins();
        put(pin_mux_select_b_addr, 16'hFE02); // keeps bits 15..9 set
        put(port_c_data_direction_addr, 16'h0101);
        check_pins();
    endtask : t_primary
    task automatic t_mux_c();
        put(pin_mux_select_c_addr, 16'hFFFF);
        rdchk(pin_mux_select_c_addr, 16'h3FFF);
        put(port_e_data_direction_addr, 16'hFF81);
        put(port_f_data_direction_addr, 16'hFFC3);
        put(port_d_data_direction_addr, 16'h8001);
        check_pins();
        put(pin_mux_select_c_addr, 16'h0000);
        check_pins();
        wr(16'h7097, 16'h0000); // reserved space only ever gets zeros
        rdchk(16'h7091, 16'h0000);
        rdchk(port_e_data_direction_addr, 16'hFF81);
        rdchk(port_f_data_direction_addr, 16'hFFC3);
        rdchk(port_d_data_direction_addr, 16'h805B);
    endtask : t_mux_c
    // bench copies of the reset selections
    task automatic copies_reset();
        mux_s = {2'b00, 14'h0001, 16'hFE03, 16'h0000};
        for (int p = 0; p < port_count; p++) begin
            port_s[p] = 16'h0000;
        end
    endtask : copies_reset
    task automatic t_reset_again();
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        copies_reset();
        rdchk(pin_mux_select_b_addr, 16'hFE03);
        rdchk(pin_mux_select_c_addr, 16'h0001);
        rdchk(port_e_data_direction_addr, 16'h000F);
        check_pins();
    endtask : t_reset_again

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        rst_b = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wr_data = '0;
        ext_level = 48'h0F0F_3366_A55A;
        copies_reset();
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_direction();
        t_primary();
        t_mux_c();
        t_reset_again();
        report_and_stop();
    end
endmodule : tb_shared_pin_gpio_mux

/* File: hdl/gpio_pin_cell.sv */
// one gpio port byte: pin mux, direction, output data and pin sampling
`timescale 1ns/100ps
module gpio_pin_cell #(
    parameter int width = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // software state
    input wire logic [width-1:0] mux_sel,
    input wire logic [width-1:0] dir,
    input wire logic [width-1:0] out_data,
    // primary function side
    input wire logic [width-1:0] prim_out,
    input wire logic [width-1:0] prim_oe,
    output logic [width-1:0] prim_in,
    // pins
    input wire logic [width-1:0] pin_in,
    output logic [width-1:0] pin_out,
    output logic [width-1:0] pin_oe,
    output logic [width-1:0] read_data
);
    wire [width-1:0] out_d;
    wire [width-1:0] oe_d;
    wire [width-1:0] rd_d;
    // primary function owns the pin when its mux bit is one
    assign out_d = (mux_sel & prim_out) | (~mux_sel & out_data); // [R1] [R5] [R7]
    assign oe_d = (mux_sel & prim_oe) | (~mux_sel & dir); // [R4] [R7]
    // input lines read the pin, output lines read back the latch
    assign rd_d = (dir & out_data) | (~dir & pin_in); // [R6]

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe <= '0;
            prim_in <= '0;
            read_data <= '0;
        end else begin
            pin_out <= out_d;
            pin_oe <= oe_d;
            prim_in <= pin_in;
            read_data <= rd_d;
        end
    end

    property p_gpio_output_follows;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !mux_sel[0] && dir[0]) |=> (pin_oe[0] && pin_out[0] == $past(out_data[0]));
    endproperty
    a_gpio_output_follows: assert property (p_gpio_output_follows) // [R5]
        else $error("gpio output line does not drive its data bit");

    property p_gpio_input_released;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !mux_sel[0] && !dir[0]) |=> !pin_oe[0];
    endproperty
    a_gpio_input_released: assert property (p_gpio_input_released) // [R4]
        else $error("gpio input line is driven");

    property p_primary_owns_pin;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && mux_sel[0]) |=>
            (pin_oe[0] == $past(prim_oe[0]) && pin_out[0] == $past(prim_out[0]));
    endproperty
    a_primary_owns_pin: assert property (p_primary_owns_pin) // [R7]
        else $error("primary function does not own pin");

    property p_input_reads_pin;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !dir[0]) |=> read_data[0] == $past(pin_in[0]);
    endproperty
    a_input_reads_pin: assert property (p_input_reads_pin) // [R6]
        else $error("input data bit does not show pin level");
endmodule : gpio_pin_cell

/* File: hdl/shared_pin_gpio_mux.sv */
// shared-pin gpio block: mux select registers and six data/direction ports
`timescale 1ns/100ps
module shared_pin_gpio_mux
    import gpio_mux_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // data space access
    input wire logic [gpio_mux_pkg::addr_w-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [gpio_mux_pkg::data_w-1:0] wr_data,
    output logic [gpio_mux_pkg::data_w-1:0] rd_data,
    output logic rd_valid,
    // mux selections seen by peripherals
    output logic [gpio_mux_pkg::data_w-1:0] mux_a,
    output logic [gpio_mux_pkg::data_w-1:0] mux_b,
    output logic [gpio_mux_pkg::data_w-1:0] mux_c,
    // peripheral primary functions, port a in the low byte
    input wire logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] prim_out,
    input wire logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] prim_oe,
    output logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] prim_in,
    // pins
    input wire logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] pin_in,
    output logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] pin_out,
    output logic [gpio_mux_pkg::port_count*gpio_mux_pkg::byte_w-1:0] pin_oe
);
    import gpio_mux_pkg::*;

    //------------------------------------------------------------
    // register decode
    //------------------------------------------------------------
    logic [data_w-1:0] mux_a_q;
    logic [data_w-1:0] mux_b_q;
    logic [data_w-1:0] mux_c_q;
    logic [byte_w-1:0] out_q [port_count];
    logic [byte_w-1:0] dir_q [port_count];
    logic [port_count*byte_w-1:0] sel_all;
    logic [port_count*byte_w-1:0] cell_rd;
    logic [port_count*byte_w-1:0] dir_all;
    logic [port_count*byte_w-1:0] out_all;
    logic [data_w-1:0] rd_d;

    function automatic int port_of(input logic [addr_w-1:0] a);
        case (a)
            port_a_data_direction_addr: port_of = port_a;
            port_b_data_direction_addr: port_of = port_b;
            port_c_data_direction_addr: port_of = port_c;
            port_d_data_direction_addr: port_of = port_d;
            port_e_data_direction_addr: port_of = port_e;
            port_f_data_direction_addr: port_of = port_f;
            default: port_of = -1;
        endcase
    endfunction : port_of

    wire hit_a = (addr == pin_mux_select_a_addr); // [R11]
    wire hit_b = (addr == pin_mux_select_b_addr); // [R11]
    wire hit_c = (addr == pin_mux_select_c_addr); // [R11]
    int sel_port;
    assign sel_port = port_of(addr); // [R11]
    wire any_hit = hit_a | hit_b | hit_c | (sel_port >= 0);

    // port order in flat vectors: a b c d e f
    // port f lines 6 and 7 have no select bit, so they stay gpio
    assign sel_all = {2'b00, mux_c_q[13:0], mux_b_q[15:0], mux_a_q[15:0]}; // [R12]

    //------------------------------------------------------------
    // mux select registers
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mux_a_q <= mux_a_reset;
            mux_b_q <= mux_b_reset; // [R9]
            mux_c_q <= mux_c_reset; // [R2]
        end else if (wr_en) begin
            if (hit_a) mux_a_q <= wr_data;
            // bits 15..9 are stored as written; software is expected to keep them set
            if (hit_b) mux_b_q <= wr_data; // [R8]
            if (hit_c) mux_c_q <= wr_data & mux_c_used_mask; // [R12]
        end
    end

    //------------------------------------------------------------
    // data and direction registers
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < port_count; i++) begin
                out_q[i] <= port_reset[byte_w-1:0];
                dir_q[i] <= port_reset[data_w-1:dir_lsb];
            end
        end else if (wr_en && sel_port >= 0) begin
            out_q[sel_port] <= wr_data[byte_w-1:0]; // [R3] [R5]
            dir_q[sel_port] <= wr_data[data_w-1:dir_lsb]; // [R3] [R4]
        end
    end

    //------------------------------------------------------------
    // port cells
    //------------------------------------------------------------
    for (genvar p = 0; p < port_count; p++) begin : g_port
        assign dir_all[p*byte_w +: byte_w] = dir_q[p];
        assign out_all[p*byte_w +: byte_w] = out_q[p];
        gpio_pin_cell #(.width(byte_w)) u_cell (
            .clock(clock),
            .rst_b(rst_b),
            .mux_sel(sel_all[p*byte_w +: byte_w]),
            .dir(dir_q[p]),
            .out_data(out_q[p]),
            .prim_out(prim_out[p*byte_w +: byte_w]),
            .prim_oe(prim_oe[p*byte_w +: byte_w]),
            .prim_in(prim_in[p*byte_w +: byte_w]),
            .pin_in(pin_in[p*byte_w +: byte_w]),
            .pin_out(pin_out[p*byte_w +: byte_w]),
            .pin_oe(pin_oe[p*byte_w +: byte_w]),
            .read_data(cell_rd[p*byte_w +: byte_w])
        );
    end

    //------------------------------------------------------------
    // read path
    //------------------------------------------------------------
    // cell_rd lags the pin by one sample, so port reads show the registered pin level
    always_comb begin
        rd_d = '0;
        if (hit_a) rd_d = mux_a_q;
        else if (hit_b) rd_d = mux_b_q;
        else if (hit_c) rd_d = mux_c_q;
        else if (sel_port >= 0) rd_d = {dir_q[sel_port], cell_rd[sel_port*byte_w +: byte_w]}; // [R3] [R6]
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
            mux_a <= mux_a_reset;
            mux_b <= mux_b_reset;
            mux_c <= mux_c_reset;
        end else begin
            rd_data <= rd_en ? rd_d : '0;
            rd_valid <= rd_en;
            mux_a <= mux_a_q;
            mux_b <= mux_b_q;
            mux_c <= mux_c_q;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    property p_reset_clock_out;
        @(posedge clock) !rst_b |=> (mux_c_q == mux_c_reset && mux_c_q[0]);
    endproperty
    a_reset_clock_out: assert property (p_reset_clock_out) // [R2]
        else $error("port e line zero not on clock output after reset");

    property p_reset_strobe;
        @(posedge clock) !rst_b |=> mux_b_q[0];
    endproperty
    a_reset_strobe: assert property (p_reset_strobe) // [R9]
        else $error("port c line zero not in strobe mode after reset");

    property p_mux_c_upper_zero;
        @(posedge clock) disable iff (!rst_b) mux_c_q[15:14] == 2'b00;
    endproperty
    a_mux_c_upper_zero: assert property (p_mux_c_upper_zero) // [R12]
        else $error("unused mux c bits set");

    property p_mux_write;
        @(posedge clock) disable iff (!rst_b)
        (wr_en && hit_a) |=> mux_a_q == $past(wr_data);
    endproperty
    a_mux_write: assert property (p_mux_write) // [R1]
        else $error("mux a write not stored");

    property p_port_write;
        @(posedge clock) disable iff (!rst_b)
        (wr_en && addr == port_e_data_direction_addr) |=>
            {dir_q[port_e], out_q[port_e]} == $past(wr_data);
    endproperty
    a_port_write: assert property (p_port_write) // [R3]
        else $error("port e data direction write not stored");

    property p_read_mux_b;
        @(posedge clock) disable iff (!rst_b)
        (rd_en && hit_b) |=> (rd_valid && rd_data == $past(mux_b_q));
    endproperty
    a_read_mux_b: assert property (p_read_mux_b) // [R11]
        else $error("mux b read wrong");

    property p_reset_ports_input;
        @(posedge clock)
        !rst_b |=> (dir_all == '0 && out_all == '0);
    endproperty
    a_reset_ports_input: assert property (p_reset_ports_input) // [R4]
        else $error("ports not inputs after reset");

    property p_reset_mux_ab;
        @(posedge clock)
        !rst_b |=> (mux_a_q == mux_a_reset && mux_b_q == mux_b_reset);
    endproperty
    a_reset_mux_ab: assert property (p_reset_mux_ab) // [R9]
        else $error("mux a or b not at reset selection");

    property p_pin_enable_all;
        @(posedge clock) disable iff (!rst_b)
        rst_b |=> pin_oe == $past((sel_all & prim_oe) | (~sel_all & dir_all));
    endproperty
    a_pin_enable_all: assert property (p_pin_enable_all) // [R4] [R7]
        else $error("pin enable not set by mux and direction");

    property p_pin_level_all;
        @(posedge clock) disable iff (!rst_b)
        rst_b |=> pin_out == $past((sel_all & prim_out) | (~sel_all & out_all));
    endproperty
    a_pin_level_all: assert property (p_pin_level_all) // [R5] [R7]
        else $error("pin level not set by mux and data");

    property p_prim_in_all;
        @(posedge clock) disable iff (!rst_b)
        rst_b |=> prim_in == $past(pin_in);
    endproperty
    a_prim_in_all: assert property (p_prim_in_all) // [R1]
        else $error("peripheral does not see pin level");

    // the data byte was sampled one edge before the read strobe
    property p_read_port_a;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && $past(rst_b) && rd_en && addr == port_a_data_direction_addr) |=>
            (rd_valid && rd_data[data_w-1:dir_lsb] == $past(dir_q[port_a])
            && (rd_data[byte_w-1:0] & ~$past(dir_q[port_a], 2))
                == ($past(pin_in[byte_w-1:0], 2) & ~$past(dir_q[port_a], 2))
            && (rd_data[byte_w-1:0] & $past(dir_q[port_a], 2))
                == ($past(out_q[port_a], 2) & $past(dir_q[port_a], 2)));
    endproperty
    a_read_port_a: assert property (p_read_port_a) // [R3] [R6]
        else $error("port a read wrong");

    property p_read_mux_a;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && rd_en && hit_a) |=> (rd_valid && rd_data == $past(mux_a_q));
    endproperty
    a_read_mux_a: assert property (p_read_mux_a) // [R11]
        else $error("mux a read wrong");

    property p_read_unmapped;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && rd_en && !any_hit) |=> (rd_valid && rd_data == '0);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) // [R11]
        else $error("unmapped read not zero");

    property p_idle_read;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !rd_en) |=> (!rd_valid && rd_data == '0);
    endproperty
    a_idle_read: assert property (p_idle_read) // [R11]
        else $error("read data without read strobe");

    property p_write_mux_b;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && wr_en && hit_b) |=> mux_b_q == $past(wr_data);
    endproperty
    a_write_mux_b: assert property (p_write_mux_b) // [R8]
        else $error("mux b write not stored");

    property p_write_mux_c;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && wr_en && hit_c) |=> mux_c_q == ($past(wr_data) & mux_c_used_mask);
    endproperty
    a_write_mux_c: assert property (p_write_mux_c) // [R12]
        else $error("mux c write not stored");

    property p_port_c_write;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && wr_en && addr == port_c_data_direction_addr) |=>
            {dir_q[port_c], out_q[port_c]} == $past(wr_data);
    endproperty
    a_port_c_write: assert property (p_port_c_write) // [R3]
        else $error("port c write not stored");

    property p_write_unmapped;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && wr_en && !any_hit) |=>
            (mux_a_q == $past(mux_a_q) && mux_b_q == $past(mux_b_q)
            && mux_c_q == $past(mux_c_q) && dir_all == $past(dir_all)
            && out_all == $past(out_all));
    endproperty
    a_write_unmapped: assert property (p_write_unmapped) // [R11]
        else $error("unmapped write changed a register");

    property p_mux_hold;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !wr_en) |=>
            (mux_a_q == $past(mux_a_q) && mux_b_q == $past(mux_b_q) && mux_c_q == $past(mux_c_q));
    endproperty
    a_mux_hold: assert property (p_mux_hold) // [R1]
        else $error("mux select changed without write");

    property p_port_hold;
        @(posedge clock) disable iff (!rst_b)
        (rst_b && !wr_en) |=> (dir_all == $past(dir_all) && out_all == $past(out_all));
    endproperty
    a_port_hold: assert property (p_port_hold) // [R3]
        else $error("port register changed without write");

    property p_mux_copies;
        @(posedge clock) disable iff (!rst_b)
        rst_b |=>
            (mux_a == $past(mux_a_q) && mux_b == $past(mux_b_q) && mux_c == $past(mux_c_q));
    endproperty
    a_mux_copies: assert property (p_mux_copies) // [R1]
        else $error("mux copies lag wrong");
endmodule : shared_pin_gpio_mux

/* File: pkg/gpio_mux_pkg.sv */
// constants for the shared-pin gpio mux block
//------------------------------------------------------------
// Overview of operation
// (R1) mux bit one selects primary, zero gpio
// (R2) port e line zero resets to clock output
// (R3) data in bits 0-7, direction 8-15
// (R4) direction zero input, one output
// (R5) output pin drives written data bit
// (R6) input pin data bit reads pin level
// (R7) data/direction ignored while primary selected
// (R8) software writes ones to mux b bits 15-9
// (R9) port c line zero resets in strobe mode
// (R10) software clears reserved bus hi-z bit
// (R11) registers decoded at 7090h through 709Eh
// (R12) mux c selects port e and f lines
//------------------------------------------------------------
package gpio_mux_pkg;
    localparam int addr_w = 16;
    localparam int data_w = 16;
    localparam int byte_w = 8;
    localparam int port_count = 6;
    localparam int dir_lsb = 8;
    localparam logic [addr_w-1:0] pin_mux_select_a_addr = 16'h7090;
    localparam logic [addr_w-1:0] pin_mux_select_b_addr = 16'h7092;
    localparam logic [addr_w-1:0] pin_mux_select_c_addr = 16'h7094;
    localparam logic [addr_w-1:0] port_e_data_direction_addr = 16'h7095;
    localparam logic [addr_w-1:0] port_f_data_direction_addr = 16'h7096;
    localparam logic [addr_w-1:0] port_a_data_direction_addr = 16'h7098;
    localparam logic [addr_w-1:0] port_b_data_direction_addr = 16'h709A;
    localparam logic [addr_w-1:0] port_c_data_direction_addr = 16'h709C;
    localparam logic [addr_w-1:0] port_d_data_direction_addr = 16'h709E;
    // reset selections
    localparam logic [data_w-1:0] mux_a_reset = 16'h0000;
    localparam logic [data_w-1:0] mux_b_reset = 16'hFE03;
    localparam logic [data_w-1:0] mux_c_reset = 16'h0001;
    localparam logic [data_w-1:0] mux_c_used_mask = 16'h3FFF;
    localparam logic [data_w-1:0] port_reset = 16'h0000;
    // port index: a b c d e f
    localparam int port_a = 0;
    localparam int port_b = 1;
    localparam int port_c = 2;
    localparam int port_d = 3;
    localparam int port_e = 4;
    localparam int port_f = 5;
endpackage : gpio_mux_pkg
